// ---- rtl/acs_pkg.sv ----
// acs_pkg: shared constants and types of the converter sequencer
package acs_pkg;

   // =====================================================================
   // widths and sizes
   localparam int RES_W     = 12;
   localparam int BUF_DEPTH = 16;
   localparam int N_INPUTS  = 13;
   localparam int SEL_W     = 5;

   // =====================================================================
   // trigger source and counts
   localparam logic [2:0] TRIG_AUTO        = 3'h7;
   localparam int         CONV_DIV_DEF     = 8;
   localparam int         SAMPLE_TICKS_DEF = 3;

   // =====================================================================
   // successive approximation start points
   localparam logic [11:0] MID_12     = 12'h800;
   localparam logic [11:0] MID_10     = 12'h200;
   localparam logic [3:0]  MSB_12     = 4'hb;
   localparam logic [3:0]  MSB_10     = 4'h9;
   localparam logic [11:0] RESULT_RST = 12'h000;

   // =====================================================================
   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_WAIT   = 4'b0100,
      ST_CONV   = 4'b1000
   } acs_state_e;

endpackage

// ---- rtl/acs_sar.sv ----
// acs_sar: successive approximation register engine
`timescale 1ns/1ps
module acs_sar import acs_pkg::*; (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // control
   input  wire logic              tick,
   input  wire logic              start,
   input  wire logic              abort,
   input  wire logic              mode_12bit,
   input  wire logic              compare_high,
   // results
   output logic      [RES_W-1:0]  trial_code,
   output logic                   busy,
   output logic                   done,
   output logic      [RES_W-1:0]  result
);

   // =====================================================================
   // state
   typedef struct packed {
      logic              busy;
      logic              armed;
      logic [3:0]        bit_idx;
      logic [RES_W-1:0]  code;
      logic              done;
      logic [RES_W-1:0]  result;
   } acs_sar_s;

   acs_sar_s s;
   acs_sar_s next_s;

   // =====================================================================
   // binary search; the comparator threshold sits half an LSB below the
   // trial code, so the search saturates on its own at both ends
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (abort) begin
         next_s.busy = 1'b0;
         next_s.code = RESULT_RST;
      end else if (start) begin
         next_s.busy    = 1'b1;
         next_s.armed   = 1'b0;
         next_s.bit_idx = mode_12bit ? MSB_12 : MSB_10;
         next_s.code    = mode_12bit ? MID_12 : MID_10;
      end else if (s.busy && tick) begin
         // first tick only lets the trial code settle
         if (!s.armed) begin
            next_s.armed = 1'b1;
         end else begin
            if (!compare_high) begin
               next_s.code[s.bit_idx] = 1'b0;
            end
            if (s.bit_idx == 4'h0) begin
               next_s.busy   = 1'b0;
               next_s.done   = 1'b1;
               next_s.result = next_s.code;
            end else begin
               next_s.bit_idx = s.bit_idx - 4'h1;
               next_s.code[s.bit_idx - 4'h1] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign trial_code = s.code;
   assign busy       = s.busy;
   assign done       = s.done;
   assign result     = s.result;

   // =====================================================================
   // checks
   midscale_start_a: assert property (@(posedge clk) disable iff (reset)
      (ce && start && !abort) |=> (s.code == (mode_12bit ? MID_12 : MID_10)))
      else $error("trial code does not start at midscale");

   ten_bit_width_a: assert property (@(posedge clk) disable iff (reset)
      (s.done && !mode_12bit) |-> (s.result[11:10] == 2'b00))
      else $error("ten bit result exceeds its range");

endmodule

// ---- rtl/acs_seq.sv ----
// acs_seq: converter sequencer with sleep and idle handling
//
// What this block does
// - sleep without rc clock stops converter clock and holds it low.
// - sleep during conversion aborts it unless rc clock is selected.
// - after sleep an aborted conversion is dropped and a fresh one starts.
// - sleep entry and exit leave counters, buffer and flags untouched.
// - with rc clock selected, sampling and converting go on during sleep.
// - each finished conversion sets done and writes the result buffer.
// - end-of-sequence interrupt in sleep raises a wake request when enabled.
// - trigger source 111 is the automatic trigger, working in sleep too when rc clock is selected.
// - stop_in_idle at 0 keeps full operation in idle.
// - stop_in_idle at 1 makes idle behave exactly like sleep.
// - two-channel mode converts sample/hold 0 then 1 on each trigger.
// - samples_per_interrupt of 7 gives the interrupt after eight conversions.
// - sampling completes before conversion; a sample period separates conversions.
// - ten-bit midscale code 0x200 sits at 512/1024 of the reference.
// - ten-bit codes saturate to all ones and zeros below half LSB.
// - twelve-bit midscale code at 2048/4096, LSB is reference/4096.
// - twelve-bit first transition at half LSB, below it all zeros.
// - the interrupt reinitialises the sequence to its first step.
// - scan visits bitmap inputs in ascending order, one per sequence.
`timescale 1ns/1ps
module acs_seq import acs_pkg::*; #(
   parameter int CONV_DIV     = CONV_DIV_DEF,
   parameter int SAMPLE_TICKS = SAMPLE_TICKS_DEF
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        ce,
   // configuration
   input  wire logic                        module_on,
   input  wire logic                        rc_clock_select,
   input  wire logic                        stop_in_idle,
   input  wire logic [2:0]                  trigger_source_select,
   input  wire logic                        start_trigger,
   input  wire logic [3:0]                  samples_per_interrupt,
   input  wire logic [1:0]                  channel_count_select,
   input  wire logic                        alternate_input_enable,
   input  wire logic                        scan_enable,
   input  wire logic [N_INPUTS-1:0]         scan_select_bitmap,
   input  wire logic [SEL_W-1:0]            ch0_input_a,
   input  wire logic [SEL_W-1:0]            ch0_input_b,
   input  wire logic [SEL_W-1:0]            ch1_input_a,
   input  wire logic [SEL_W-1:0]            ch1_input_b,
   input  wire logic                        mode_12bit,
   input  wire logic                        done_clear,
   input  wire logic                        interrupt_enable,
   // power controller
   input  wire logic                        sleep_mode,
   input  wire logic                        idle_mode,
   // analog front end
   input  wire logic                        rc_osc,
   input  wire logic                        compare_high,
   output logic                             conv_clock,
   output logic                             sample_hold_0,
   output logic                             sample_hold_1,
   output logic [SEL_W-1:0]                 input_select,
   output logic [RES_W-1:0]                 dac_code,
   // status and results
   output logic                             done,
   output logic                             busy,
   output logic                             adc_interrupt,
   output logic                             wake_request,
   output logic [3:0]                       buffer_index,
   output logic [BUF_DEPTH*RES_W-1:0]       result_buffer
);

   // =====================================================================
   // state
   typedef struct packed {
      acs_state_e                        state;
      logic                              ch;
      logic [7:0]                        sample_cnt;
      logic [7:0]                        div_cnt;
      logic                              conv_clock;
      logic [2:0]                        rc_sync;
      logic                              rc_level;
      logic [2:0]                        cmp_sync;
      logic                              cmp_level;
      logic                              alt_b;
      logic [3:0]                        scan_ptr;
      logic [3:0]                        conv_cnt;
      logic [3:0]                        buf_ptr;
      logic [BUF_DEPTH-1:0][RES_W-1:0]   bufw;
      logic                              done;
      logic                              irq;
      logic                              wake;
      logic [SEL_W-1:0]                  input_sel;
      logic                              sh0;
      logic                              sh1;
      logic                              sar_start;
      logic                              sar_abort;
   } acs_seq_s;

   acs_seq_s s;
   acs_seq_s next_s;

   logic              stopped;
   logic              halted;
   logic              conv_done;
   logic              irq_event;
   logic              sar_busy;
   logic              sar_done;
   logic [RES_W-1:0]  sar_result;
   logic              tick;

   // =====================================================================
   // lowest marked input at or above the pointer, else the lowest overall
   function automatic logic [3:0] next_scan(input logic [N_INPUTS-1:0] bm,
                                            input logic [3:0]          from);
      logic [3:0] pick;
      logic       found;
      pick  = 4'h0;
      found = 1'b0;
      for (int i = N_INPUTS - 1; i >= 0; i--) begin
         if (bm[i] && (4'(i) >= from)) begin
            pick  = 4'(i);
            found = 1'b1;
         end
      end
      if (!found) begin
         for (int i = N_INPUTS - 1; i >= 0; i--) begin
            if (bm[i]) begin
               pick = 4'(i);
            end
         end
      end
      return pick;
   endfunction

   // =====================================================================
   // power state
   assign stopped   = sleep_mode | (idle_mode & stop_in_idle);
   assign halted    = stopped & ~rc_clock_select;
   assign conv_done = sar_done && (s.state == ST_CONV);
   assign irq_event = conv_done && (s.conv_cnt == samples_per_interrupt);

   // =====================================================================
   // conversion clock: system divider, or rc oscillator edges
   always_comb begin
      tick = 1'b0;
      if (!(halted || !module_on)) begin
         if (rc_clock_select) begin
            tick = (s.rc_sync[2] == s.rc_sync[1]) && s.rc_sync[1] && !s.rc_level;
         end else begin
            tick = (s.div_cnt == 8'(CONV_DIV - 1));
         end
      end
   end

   // =====================================================================
   // sequencer
   always_comb begin
      logic [3:0] scan_cur;
      logic       use_b;
      logic       two_ch;
      logic       go;
      scan_cur = next_scan(scan_select_bitmap, s.scan_ptr);
      use_b    = alternate_input_enable & s.alt_b;
      two_ch   = (channel_count_select != 2'b00);
      go       = (trigger_source_select == TRIG_AUTO) || start_trigger;

      next_s           = s;
      next_s.sar_start = 1'b0;
      next_s.sar_abort = 1'b0;
      next_s.irq       = 1'b0;
      next_s.wake      = 1'b0;

      // pin synchronisers; a change counts once stages two and three agree
      next_s.rc_sync  = {s.rc_sync[1:0], rc_osc};
      next_s.cmp_sync = {s.cmp_sync[1:0], compare_high};
      if (s.rc_sync[2] == s.rc_sync[1]) begin
         next_s.rc_level = s.rc_sync[1];
      end
      if (s.cmp_sync[2] == s.cmp_sync[1]) begin
         next_s.cmp_level = s.cmp_sync[1];
      end

      // clock held low while stopped without the rc source
      if (halted || !module_on) begin
         next_s.div_cnt    = 8'h00;
         next_s.conv_clock = 1'b0;
      end else if (rc_clock_select) begin
         next_s.conv_clock = s.rc_level;
      end else begin
         next_s.div_cnt    = tick ? 8'h00 : s.div_cnt + 8'h01;
         next_s.conv_clock = (s.div_cnt < 8'(CONV_DIV / 2));
      end

      if (done_clear) begin
         next_s.done = 1'b0;
      end

      case (s.state)
         ST_IDLE: begin
            if (module_on && !halted) begin
               next_s.state      = ST_SAMPLE;
               next_s.ch         = 1'b0;
               next_s.sample_cnt = 8'h00;
               next_s.sh0        = 1'b1;
               if (use_b) begin
                  next_s.input_sel = ch0_input_b;
               end else if (scan_enable) begin
                  next_s.input_sel = {1'b0, scan_cur};
               end else begin
                  next_s.input_sel = ch0_input_a;
               end
            end
         end
         ST_SAMPLE: begin
            // the whole sample period runs before any conversion
            if (tick) begin
               if (s.sample_cnt == 8'(SAMPLE_TICKS - 1)) begin
                  next_s.sample_cnt = 8'h00;
                  if (s.ch) begin
                     next_s.state     = ST_CONV;
                     next_s.sh1       = 1'b0;
                     next_s.sar_start = 1'b1;
                  end else begin
                     next_s.state = ST_WAIT;
                  end
               end else begin
                  next_s.sample_cnt = s.sample_cnt + 8'h01;
               end
            end
         end
         ST_WAIT: begin
            if (go) begin
               next_s.state     = ST_CONV;
               next_s.sh0       = 1'b0;
               next_s.sar_start = 1'b1;
            end
         end
         ST_CONV: begin
            if (sar_done) begin
               next_s.done              = 1'b1;
               next_s.bufw[s.buf_ptr]   = sar_result;
               next_s.buf_ptr           = s.buf_ptr + 4'h1;
               next_s.conv_cnt          = s.conv_cnt + 4'h1;
               if (two_ch && !s.ch) begin
                  next_s.state      = ST_SAMPLE;
                  next_s.ch         = 1'b1;
                  next_s.sh1        = 1'b1;
                  next_s.sample_cnt = 8'h00;
                  next_s.input_sel  = use_b ? ch1_input_b : ch1_input_a;
               end else begin
                  next_s.state = ST_IDLE;
                  if (alternate_input_enable) begin
                     next_s.alt_b = ~s.alt_b;
                  end
                  if (scan_enable && !use_b) begin
                     next_s.scan_ptr = scan_cur + 4'h1;
                  end
               end
            end
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase

      // interrupt restarts the sequence from its first step
      if (irq_event) begin
         next_s.irq      = 1'b1;
         next_s.wake     = interrupt_enable & stopped;
         next_s.conv_cnt = 4'h0;
         next_s.buf_ptr  = 4'h0;
         next_s.alt_b    = 1'b0;
         next_s.scan_ptr = 4'h0;
         next_s.ch       = 1'b0;
         next_s.sh1      = 1'b0;
         next_s.state    = ST_IDLE;
      end

      // counters, buffer and flags survive; only the sequence is dropped
      if ((halted || !module_on) && (s.state != ST_IDLE)) begin
         next_s.state      = ST_IDLE;
         next_s.sh0        = 1'b0;
         next_s.sh1        = 1'b0;
         next_s.sample_cnt = 8'h00;
         next_s.sar_abort  = 1'b1;
         next_s.sar_start  = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
         s.state <= ST_IDLE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // =====================================================================
   // approximation engine; compare level is already synchronised
   acs_sar u_sar (
      .clk          (clk),
      .reset        (reset),
      .ce           (ce),
      .tick         (tick),
      .start        (s.sar_start),
      .abort        (s.sar_abort),
      .mode_12bit   (mode_12bit),
      .compare_high (s.cmp_level),
      .trial_code   (dac_code),
      .busy         (sar_busy),
      .done         (sar_done),
      .result       (sar_result)
   );

   // =====================================================================
   // outputs
   assign conv_clock    = s.conv_clock;
   assign sample_hold_0 = s.sh0;
   assign sample_hold_1 = s.sh1;
   assign input_select  = s.input_sel;
   assign done          = s.done;
   assign busy          = sar_busy;
   assign adc_interrupt = s.irq;
   assign wake_request  = s.wake;
   assign buffer_index  = s.buf_ptr;
   assign result_buffer = s.bufw;

   // =====================================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence conv_entry_s;
      ##1 (s.state == ST_CONV) ##1 sar_busy;
   endsequence

   clock_low_a: assert property ((ce && halted) |=> !conv_clock)
      else $error("converter clock not held low while stopped");

   abort_stop_a: assert property ((ce && halted && s.state != ST_IDLE) |=> (s.state == ST_IDLE))
      else $error("conversion not aborted on stop");

   fresh_start_a: assert property ((s.state == ST_IDLE) |=> (s.state != ST_CONV))
      else $error("conversion resumed without fresh sampling");

   regs_kept_a: assert property ((ce && halted && s.state == ST_IDLE) |=>
      ($stable(s.conv_cnt) && $stable(s.buf_ptr) && $stable(s.bufw)))
      else $error("state lost across sleep");

   result_store_a: assert property ((ce && conv_done && !halted && module_on) |=>
      (done && s.bufw[$past(s.buf_ptr)] == $past(sar_result)))
      else $error("finished conversion not stored");

   wake_up_a: assert property ((ce && irq_event && interrupt_enable && stopped) |=> wake_request)
      else $error("no wake request from sleep interrupt");

   auto_trig_a: assert property ((ce && s.state == ST_WAIT && trigger_source_select == TRIG_AUTO
      && module_on && !halted) |-> conv_entry_s)
      else $error("automatic trigger did not start conversion");

   idle_runs_a: assert property ((ce && idle_mode && !sleep_mode && !stop_in_idle && module_on
      && s.state == ST_IDLE) |=> (s.state == ST_SAMPLE))
      else $error("block stopped in idle");

   second_ch_a: assert property ((ce && conv_done && !irq_event && !s.ch && !halted && module_on
      && channel_count_select != 2'b00) |=> (s.state == ST_SAMPLE && s.ch && sample_hold_1))
      else $error("second channel not sampled after first");

   sample_first_a: assert property ($rose(s.state == ST_CONV) |->
      ($past(s.state) == ST_WAIT || $past(s.state) == ST_SAMPLE))
      else $error("conversion started without sampling");

   irq_restart_a: assert property ((ce && irq_event) |=>
      (adc_interrupt && s.conv_cnt == 4'h0 && s.buf_ptr == 4'h0 && s.state == ST_IDLE))
      else $error("interrupt did not restart sequence");

endmodule

// ---- tb/acs_afe.sv ----
// acs_afe: analog front end model with sample capacitors, comparator and rc oscillator
`timescale 1ns/1ps
module acs_afe import acs_pkg::*; (
   // sampling side
   input  wire logic             sample_hold_0,
   input  wire logic             sample_hold_1,
   input  wire logic [SEL_W-1:0] input_select,
   input  wire logic [RES_W-1:0] dac_code,
   input  wire logic             mode_12bit,
   // input levels, units of reference/8192
   input  wire logic [12:0]      vin [N_INPUTS],
   // comparator and oscillator
   output logic                  compare_high,
   output logic                  rc_osc
);
   logic [12:0] held [2];
   logic        conv_ch = 1'h0;
   initial rc_osc = 1'h0;
   // free running, unrelated in phase and rate to clk
   always #115 rc_osc = ~rc_osc;
   always @* begin
      if (sample_hold_0) held[0] = vin[input_select];
      if (sample_hold_1) held[1] = vin[input_select];
   end
   always @(negedge sample_hold_0) conv_ch = 1'h0;
   always @(negedge sample_hold_1) conv_ch = 1'h1;
   // threshold sits half a step below the trial code
   assign compare_high = int'(held[conv_ch]) >= (2 * int'(dac_code) - 1) * (mode_12bit ? 1 : 4);
endmodule

// ---- tb/adc_sequencer_low_power_bench.sv ----
// adc_sequencer_low_power_bench: self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adc_sequencer_low_power_bench import acs_pkg::*;;
   logic clk = 1'h0, reset = 1'h1, module_on, rc_clock_select, stop_in_idle, seen;
   logic alternate_input_enable, scan_enable, mode_12bit, interrupt_enable, sleep_mode, idle_mode;
   logic [3:0] samples_per_interrupt, buffer_index;
   logic [1:0] channel_count_select;
   logic ce, start_trigger, done_clear;
   logic [2:0] trigger_source_select;
   logic [N_INPUTS-1:0] scan_select_bitmap;
   logic [12:0] vin [N_INPUTS];
   logic rc_osc, compare_high, conv_clock, sample_hold_0, sample_hold_1, done, busy, adc_interrupt, wake_request;
   logic [SEL_W-1:0] input_select;
   logic [RES_W-1:0] dac_code;
   logic [BUF_DEPTH*RES_W-1:0] result_buffer;
   int errors = 0, total_checks = 0, cycles = 0, conv_cnt = 0;

   // =====================================================================
   // design and front end
   acs_seq #(.CONV_DIV(8), .SAMPLE_TICKS(3)) DUT (.clk(clk), .reset(reset), .ce(ce), .module_on(module_on),
      .rc_clock_select(rc_clock_select), .stop_in_idle(stop_in_idle), .start_trigger(start_trigger),
      .trigger_source_select(trigger_source_select), .samples_per_interrupt(samples_per_interrupt),
      .channel_count_select(channel_count_select), .alternate_input_enable(alternate_input_enable),
      .scan_enable(scan_enable), .scan_select_bitmap(scan_select_bitmap), .mode_12bit(mode_12bit),
      .ch0_input_a(5'h05), .ch0_input_b(5'h08), .ch1_input_a(5'h00), .ch1_input_b(5'h04), .done_clear(done_clear),
      .interrupt_enable(interrupt_enable), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
      .rc_osc(rc_osc), .compare_high(compare_high), .conv_clock(conv_clock), .sample_hold_0(sample_hold_0),
      .sample_hold_1(sample_hold_1), .input_select(input_select), .dac_code(dac_code), .done(done), .busy(busy),
      .adc_interrupt(adc_interrupt), .wake_request(wake_request), .buffer_index(buffer_index),
      .result_buffer(result_buffer));
   acs_afe afe (.sample_hold_0(sample_hold_0), .sample_hold_1(sample_hold_1), .input_select(input_select),
      .dac_code(dac_code), .mode_12bit(mode_12bit), .vin(vin), .compare_high(compare_high), .rc_osc(rc_osc));

   // =====================================================================
   // helpers
   always #10 clk = ~clk;
   always @(negedge busy) conv_cnt++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_val(input string name, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk_val(name, {11'h000, exp}, {11'h000, got});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ideal code: round to nearest step, saturate at full scale
   function automatic logic [11:0] code_of(input int v, input logic m12);
      int lsb = m12 ? 2 : 8;
      int c = (v + lsb / 2) / lsb;
      int top = m12 ? 4095 : 1023;
      return 12'(c > top ? top : c);
   endfunction
   // irq high waits for adc_interrupt, else for busy; seen notes sampling on the way
   task automatic wait_on(input logic irq);
      int n = 0;
      seen = 1'h0;
      while ((irq ? adc_interrupt : busy) !== 1'h1 && n < 5000) begin
         step(1);
         n++;
         seen |= sample_hold_0;
      end
      chk_bit("handshake", 1'h1, irq ? adc_interrupt : busy);
   endtask
   task automatic restart();
      reset = 1'h1;
      {module_on, rc_clock_select, stop_in_idle, alternate_input_enable, scan_enable} = '0;
      {interrupt_enable, sleep_mode, idle_mode, channel_count_select, samples_per_interrupt} = '0;
      mode_12bit = 1'h1;
      {ce, start_trigger, done_clear} = 3'h4;
      trigger_source_select = TRIG_AUTO;
      scan_select_bitmap = '0;
      for (int k = 0; k < N_INPUTS; k++) vin[k] = 13'(k * 600 + 101);
      step(2);
      reset = 1'h0;
      conv_cnt = 0;
   endtask

   // =====================================================================
   // scenarios
   task automatic scan_case(input logic m12, input logic [12:0] v [4]);
      int ins [4] = '{1, 4, 7, 9};
      restart();
      mode_12bit = m12;
      scan_enable = 1'h1;
      scan_select_bitmap = 13'h0292;
      samples_per_interrupt = 4'h3;
      for (int k = 0; k < 4; k++) vin[ins[k]] = v[k];
      module_on = 1'h1;
      wait_on(1'h1);
      for (int k = 0; k < 4; k++) chk_val("scan word", code_of(v[k], m12), result_buffer[12*k +: 12]);
   endtask
   task automatic pair_case();
      int order [8] = '{2, 0, 8, 4, 3, 0, 8, 4};
      restart();
      {channel_count_select, alternate_input_enable, scan_enable} = 4'h7;
      scan_select_bitmap = 13'h000c;
      samples_per_interrupt = 4'h7;
      module_on = 1'h1;
      wait_on(1'h1);
      chk_val("conversions", 12'h008, 12'(conv_cnt));
      for (int k = 0; k < 8; k++) chk_val("pair word", code_of(vin[order[k]], 1'h1), result_buffer[12*k +: 12]);
      chk_val("index", 12'h000, {8'h00, buffer_index});
   endtask
   // manual trigger, frozen clock enable and done clear
   task automatic ctl_case();
      logic [11:0] code;
      restart();
      trigger_source_select = 3'h0;
      module_on = 1'h1;
      step(80);
      chk_bit("trigger wait", 1'h0, busy);
      chk_bit("held sample", 1'h1, sample_hold_0);
      start_trigger = 1'h1;
      step(1);
      start_trigger = 1'h0;
      wait_on(1'h0);
      ce = 1'h0;
      code = dac_code;
      step(40);
      chk_val("frozen code", code, dac_code);
      chk_bit("frozen busy", 1'h1, busy);
      ce = 1'h1;
      wait_on(1'h1);
      chk_bit("done", 1'h1, done);
      chk_val("word", code_of(vin[5], 1'h1), result_buffer[11:0]);
      done_clear = 1'h1;
      step(1);
      done_clear = 1'h0;
      chk_bit("done cleared", 1'h0, done);
   endtask
   // k: 0 sleep, 1 idle stopping, 2 idle running, 3 sleep on rc clock
   task automatic pm_case(input int k);
      logic [3:0] idx;
      restart();
      rc_clock_select = 1'(k == 3);
      stop_in_idle = 1'(k == 1);
      interrupt_enable = 1'h1;
      module_on = 1'h1;
      wait_on(1'h0);
      idx = buffer_index;
      sleep_mode = 1'(k == 0 || k == 3);
      idle_mode = 1'(k == 1 || k == 2);
      if (k < 2) begin
         step(2);
         repeat (20) begin
            chk_bit("conv clock", 1'h0, conv_clock);
            chk_bit("busy", 1'h0, busy);
            step(1);
         end
         chk_val("index kept", {8'h00, idx}, {8'h00, buffer_index});
         {sleep_mode, idle_mode} = 2'h0;
         wait_on(1'h0);
         chk_bit("sampled first", 1'h1, seen);
      end
      wait_on(1'h1);
      if (k == 3) chk_bit("wake", 1'h1, wake_request);
      chk_bit("done", 1'h1, done);
      chk_val("word", code_of(vin[5], 1'h1), result_buffer[11:0]);
      step(1);
      chk_bit("resampled", 1'h1, sample_hold_0);
   endtask

   initial begin
      restart();
      chk_bit("done", 1'h0, done);
      chk_bit("conv clock", 1'h0, conv_clock);
      scan_case(1'h1, '{13'h0000, 13'h0001, 13'h1000, 13'h1fff});
      scan_case(1'h0, '{13'h0003, 13'h0004, 13'h1000, 13'h1ff5});
      pair_case();
      ctl_case();
      for (int k = 0; k < 4; k++) pm_case(k);
      tally_and_finish();
   end
endmodule
